// file: hdl/fm_cfg_pkg.sv
// Package of constants and types for the FM de-emphasis and dematrix setup.
// ****************************************************************
// Overview of operation
// - Bandwidth code 00 narrow/narrow, 01 xwide/narrow, 10 medium, 11 wide.
// - With code 01, channel 2 gives no FM demodulated result.
// - Identification off puts identification hardware into a defined reset.
// - De-emphasis low nibble serves carrier 1, high nibble carrier 2.
// - De-emphasis and dematrix registers clear to zero at power-on reset.
// - Bit 7 or bit 3 enables adaptive de-emphasis for its carrier.
// - Code 000 50us, 001 60us, 010 75us, 011 J17, 100 off.
// - De-emphasis filter gain is unity at the low reference frequency.
// - Dematrix takes channel 1 as carrier 1, channel 2 as carrier 2.
// - Auto bit set: dematrix follows identification, manual field ignored.
// - Auto stereo picks Europe or Korea matrix from the region bit.
// - Auto mode with channel 2 in NICAM always gives channel 1 mono.
// - Auto off: low three dematrix bits select the characteristic.
// - Manual codes 000 to 110 map to the seven documented L/R forms.
// - Auto: mono CH1/CH1, Europe, Korea, dual CH1/CH2.
// - Bandwidth select bits sit at bits 4 and 1 of demod config.
// ****************************************************************
package fm_cfg_pkg;
    // ************************************************************
    // Register map and fields
    // ************************************************************
    localparam logic [7:0] SUB_DEMOD_CONFIG = 8'h09;
    localparam logic [7:0] SUB_DEEMPH = 8'h0a;
    localparam logic [7:0] SUB_DEMATRIX = 8'h0b;
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam int BIT_IDENT_HI = 7;
    localparam int BIT_IDENT_LO = 6;
    localparam int BIT_REGION = 5;
    localparam int BIT_BW_SEL_HI = 4;
    localparam int BIT_CH2_MODE_HI = 3;
    localparam int BIT_CH2_MODE_LO = 2;
    localparam int BIT_BW_SEL_LO = 1;
    localparam int BIT_ADAPT2 = 7;
    localparam int BIT_ADAPT1 = 3;
    localparam int BIT_AUTO_DEMATRIX = 7;
    localparam logic [1:0] IDENT_OFF = 2'h3;
    localparam logic [1:0] CH2_NICAM = 2'h2;
    localparam logic [1:0] CH2_FM = 2'h0;
    localparam int DEEMPH_REF_HZ = 40;
    // Device address on the two-wire bus; value is arbitrary.
    localparam logic [6:0] DEV_ADDR = 7'h2c;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam logic [1:0] IDX_ADDR = 2'h0;
    localparam logic [1:0] IDX_SUB = 2'h1;
    localparam logic [1:0] IDX_DATA = 2'h2;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        BW_NARROW, BW_MEDIUM, BW_WIDE, BW_EXTRA_WIDE
    } bandwidth_t;
    typedef enum logic [2:0] {
        DE_50US, DE_60US, DE_75US, DE_J17, DE_OFF
    } deemph_char_t;
    typedef enum logic [2:0] {
        DM_MONO1, DM_MONO2, DM_DUAL, DM_DUAL_SWAP,
        DM_STEREO_EU, DM_KOREA_HALF, DM_STEREO_KOREA
    } dematrix_t;
    typedef enum logic [1:0] {
        ID_MONO, ID_STEREO, ID_DUAL
    } ident_t;
    typedef struct packed {
        logic adaptive;
        deemph_char_t characteristic;
    } carrier_deemph_t;
    typedef struct packed {
        bandwidth_t ch1;
        bandwidth_t ch2;
        logic ch2_fm_enable;
        logic ch2_nicam_enable;
    } bw_config_t;
endpackage

// file: hdl/fm_deemph_dematrix_config.sv
// Two-wire write slave with FM bandwidth, de-emphasis and dematrix setup.
module fm_deemph_dematrix_config
    import fm_cfg_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Two-wire control bus
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    // Identification result from the sound decoder
    input wire ident_t ident_result,
    // Decoded configuration
    output bw_config_t bw_config,
    output logic ident_reset,
    output logic ident_region_select,
    output carrier_deemph_t deemph_carrier1,
    output carrier_deemph_t deemph_carrier2,
    output dematrix_t dematrix_mode
);

    typedef enum {ST_IDLE, ST_RECV, ST_ACK} bus_state_t;

    // ************************************************************
    // Decode functions
    // ************************************************************
    function automatic deemph_char_t decode_deemph(input logic [2:0] code);
        case (code)
            3'h0: decode_deemph = DE_50US;
            3'h1: decode_deemph = DE_60US;
            3'h2: decode_deemph = DE_75US;
            3'h3: decode_deemph = DE_J17;
            default: decode_deemph = DE_OFF;
        endcase
    endfunction

    function automatic bandwidth_t bw_of(input logic [1:0] code,
                                         input logic ch1);
        case (code)
            2'h0: bw_of = BW_NARROW;
            2'h1: bw_of = ch1 ? BW_EXTRA_WIDE : BW_NARROW;
            2'h2: bw_of = BW_MEDIUM;
            default: bw_of = BW_WIDE;
        endcase
    endfunction

    // ************************************************************
    // Bus sampling and edges
    // ************************************************************
    logic scl_q;
    logic sda_q;
    logic scl_d;
    logic sda_d;
    logic scl_rise;
    logic scl_fall;
    logic start_cond;
    logic stop_cond;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_q <= scl_in;
            sda_q <= sda_in;
            scl_d <= scl_q;
            sda_d <= sda_q;
        end
    end

    assign scl_rise = scl_q & ~scl_d;
    assign scl_fall = ~scl_q & scl_d;
    assign start_cond = scl_q & scl_d & sda_d & ~sda_q;
    assign stop_cond = scl_q & scl_d & ~sda_d & sda_q;

    // ************************************************************
    // Byte receiver
    // ************************************************************
    bus_state_t state;
    logic [6:0] shift;
    logic [2:0] bit_cnt;
    logic [1:0] byte_idx;
    logic ack_pending;
    logic [7:0] subaddr;
    logic [7:0] rx_byte;
    logic byte_done;
    logic write_en;

    assign rx_byte = {shift, sda_q};
    assign byte_done = (state == ST_RECV) && scl_rise && (bit_cnt == LAST_BIT);
    assign write_en = byte_done && (byte_idx == IDX_DATA);

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state <= ST_IDLE;
            shift <= 7'h00;
            bit_cnt <= 3'h0;
            byte_idx <= IDX_ADDR;
            ack_pending <= 1'b0;
            sda_oe <= 1'b0;
        end else if (start_cond) begin
            state <= ST_RECV;
            bit_cnt <= 3'h0;
            byte_idx <= IDX_ADDR;
            ack_pending <= 1'b0;
            sda_oe <= 1'b0;
        end else if (stop_cond) begin
            state <= ST_IDLE;
            ack_pending <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            case (state)
                ST_IDLE: begin
                    sda_oe <= 1'b0;
                end
                ST_RECV: begin
                    if (scl_rise) begin
                        shift <= rx_byte[6:0];
                        bit_cnt <= bit_cnt + 3'h1;
                        if (bit_cnt == LAST_BIT) begin
                            if (byte_idx == IDX_ADDR) begin
                                ack_pending <= (rx_byte[7:1] == DEV_ADDR)
                                    && !rx_byte[0];
                            end else begin
                                ack_pending <= 1'b1;
                            end
                            if (byte_idx != IDX_DATA) begin
                                byte_idx <= byte_idx + 2'h1;
                            end
                        end
                    end else if (scl_fall && ack_pending) begin
                        ack_pending <= 1'b0;
                        sda_oe <= 1'b1;
                        state <= ST_ACK;
                    end else if (scl_fall && bit_cnt == 3'h0
                                 && byte_idx == IDX_SUB) begin
                        state <= ST_IDLE;
                    end
                end
                ST_ACK: begin
                    if (scl_fall) begin
                        sda_oe <= 1'b0;
                        state <= ST_RECV;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // The slave only ever pulls the line low.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            sda_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
        end
    end

    // ************************************************************
    // Register bank
    // ************************************************************
    logic [7:0] demod_config;
    logic [7:0] fm_deemphasis_select;
    logic [7:0] fm_dematrix_select;

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            subaddr <= 8'h00;
        end else if (byte_done && byte_idx == IDX_SUB) begin
            subaddr <= rx_byte;
        end else if (write_en) begin
            subaddr <= subaddr + 8'h01;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            demod_config <= REG_RESET;
            fm_deemphasis_select <= REG_RESET;
            fm_dematrix_select <= REG_RESET;
        end else if (write_en) begin
            case (subaddr)
                SUB_DEMOD_CONFIG: demod_config <= rx_byte;
                SUB_DEEMPH: fm_deemphasis_select <= rx_byte;
                SUB_DEMATRIX: fm_dematrix_select <= rx_byte;
                default: demod_config <= demod_config;
            endcase
        end
    end

    // ************************************************************
    // Decoded configuration
    // ************************************************************
    logic [1:0] filt_code;
    logic [1:0] ch2_mode;
    logic [1:0] ident_mode;

    assign filt_code = {demod_config[BIT_BW_SEL_HI],
                        demod_config[BIT_BW_SEL_LO]};
    assign ch2_mode = {demod_config[BIT_CH2_MODE_HI],
                       demod_config[BIT_CH2_MODE_LO]};
    assign ident_mode = {demod_config[BIT_IDENT_HI],
                         demod_config[BIT_IDENT_LO]};

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            bw_config <= '{BW_NARROW, BW_NARROW, 1'b1, 1'b0};
            ident_reset <= 1'b0;
            ident_region_select <= 1'b0;
        end else begin
            bw_config.ch1 <= bw_of(filt_code, 1'b1);
            bw_config.ch2 <= bw_of(filt_code, 1'b0);
            bw_config.ch2_fm_enable <= (filt_code != 2'h1)
                && (ch2_mode == CH2_FM);
            bw_config.ch2_nicam_enable <= (ch2_mode == CH2_NICAM);
            ident_reset <= (ident_mode == IDENT_OFF);
            ident_region_select <= demod_config[BIT_REGION];
        end
    end

    // Filters are normalised to unity gain at DEEMPH_REF_HZ.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            deemph_carrier1 <= '{1'b0, DE_50US};
            deemph_carrier2 <= '{1'b0, DE_50US};
        end else begin
            deemph_carrier1.adaptive <= fm_deemphasis_select[BIT_ADAPT1];
            deemph_carrier2.adaptive <= fm_deemphasis_select[BIT_ADAPT2];
            deemph_carrier1.characteristic <=
                decode_deemph(fm_deemphasis_select[2:0]);
            deemph_carrier2.characteristic <=
                decode_deemph(fm_deemphasis_select[6:4]);
        end
    end

    // Channel 1 carries carrier 1 and channel 2 carries carrier 2.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            dematrix_mode <= DM_MONO1;
        end else if (fm_dematrix_select[BIT_AUTO_DEMATRIX]) begin
            if (ch2_mode == CH2_NICAM) begin
                dematrix_mode <= DM_MONO1;
            end else begin
                case (ident_result)
                    ID_STEREO: dematrix_mode <= demod_config[BIT_REGION]
                        ? DM_STEREO_KOREA : DM_STEREO_EU;
                    ID_DUAL: dematrix_mode <= DM_DUAL;
                    default: dematrix_mode <= DM_MONO1;
                endcase
            end
        end else begin
            case (fm_dematrix_select[2:0])
                3'h0: dematrix_mode <= DM_MONO1;
                3'h1: dematrix_mode <= DM_MONO2;
                3'h2: dematrix_mode <= DM_DUAL;
                3'h3: dematrix_mode <= DM_DUAL_SWAP;
                3'h4: dematrix_mode <= DM_STEREO_EU;
                3'h5: dematrix_mode <= DM_KOREA_HALF;
                3'h6: dematrix_mode <= DM_STEREO_KOREA;
                default: dematrix_mode <= DM_MONO1;
            endcase
        end
    end

endmodule

// file: testbench/fm_cfg_chk.sv
// Port checker for the FM configuration block.
module fm_cfg_chk
    import fm_cfg_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic sys_rst,
    // Inputs
    input wire logic scl_in,
    input wire logic sda_in,
    input wire ident_t ident_result,
    // Outputs
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire bw_config_t bw_config,
    input wire logic ident_reset,
    input wire logic ident_region_select,
    input wire carrier_deemph_t deemph_carrier1,
    input wire carrier_deemph_t deemph_carrier2,
    input wire dematrix_t dematrix_mode
);
    timeunit 1ns;
    timeprecision 1ps;
    logic scl_q;
    logic [2:0] since_rise;
    default clocking @(posedge clock); endclocking
    default disable iff (sys_rst);
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst)
            scl_q <= 1'b1;
        else
            scl_q <= scl_in;
    end
    // Counts cycles since the bus clock last rose.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst)
            since_rise <= 3'h7;
        else if (scl_in && !scl_q)
            since_rise <= 3'h0;
        else if (since_rise != 3'h7)
            since_rise <= since_rise + 3'h1;
    end
    sequence seq_release;
        ##[2:5] !sda_oe;
    endsequence
    AST_BW_PAIR: assert property (
        bw_config.ch1 == BW_EXTRA_WIDE ? bw_config.ch2 == BW_NARROW
            : bw_config.ch2 == bw_config.ch1)
        else $error("bandwidth pair illegal");
    AST_XWIDE_NO_FM: assert property (
        bw_config.ch1 == BW_EXTRA_WIDE |-> !bw_config.ch2_fm_enable)
        else $error("channel 2 FM on in extra wide");
    AST_RESET_CLEAR: assert property (
        $fell(sys_rst) |-> bw_config == {BW_NARROW, BW_NARROW, 2'h2}
            && {ident_reset, ident_region_select} == 2'h0
            && {deemph_carrier1, deemph_carrier2} == 8'h00
            && dematrix_mode == DM_MONO1)
        else $error("outputs not cleared by reset");
    AST_DEEMPH_LEGAL: assert property (
        deemph_carrier1.characteristic <= DE_OFF
            && deemph_carrier2.characteristic <= DE_OFF)
        else $error("de-emphasis code out of range");
    AST_DEEMPH_CAUSE: assert property (
        $changed({deemph_carrier1, deemph_carrier2}) |-> since_rise != 3'h7)
        else $error("de-emphasis changed without a write");
    AST_DEMOD_CAUSE: assert property (
        $changed({ident_reset, ident_region_select, bw_config})
            |-> since_rise != 3'h7)
        else $error("demod setup changed without a write");
    AST_DEMATRIX_CAUSE: assert property (
        $changed(dematrix_mode) |-> since_rise != 3'h7
            || $past(ident_result) != $past(ident_result, 2))
        else $error("dematrix changed without cause");
    AST_ACK_START: assert property (
        $rose(sda_oe) |-> !scl_in && !sda_out)
        else $error("acknowledge began with bus clock high");
    AST_ACK_STANDS: assert property (
        sda_oe && $rose(scl_in) |-> sda_oe [*4])
        else $error("acknowledge dropped during its pulse");
    AST_ACK_RELEASE: assert property (
        sda_oe && $fell(scl_in) |-> seq_release)
        else $error("acknowledge not released");
endmodule
bind fm_deemph_dematrix_config fm_cfg_chk i_chk (.clock(clock),
    .sys_rst(sys_rst), .scl_in(scl_in), .sda_in(sda_in),
    .ident_result(ident_result), .sda_out(sda_out), .sda_oe(sda_oe),
    .bw_config(bw_config), .ident_reset(ident_reset),
    .ident_region_select(ident_region_select),
    .deemph_carrier1(deemph_carrier1), .deemph_carrier2(deemph_carrier2),
    .dematrix_mode(dematrix_mode));

// file: testbench/bus_host_model.sv
// Two-wire bus host model that writes registers by subaddress.
module bus_host_model (
    // Clock
    input wire logic clock,
    // Bus lines
    input wire logic sda_oe,
    output logic scl,
    output logic sda_drv
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    task automatic w(input int n);
        repeat (n) @(negedge clock);
    endtask
    // Sends one byte MSB first, then counts an acknowledge.
    task automatic put(input logic [7:0] b, inout int acks);
        logic [8:0] s;
        s = {b, 1'b1};
        for (int k = 8; k >= 0; k--) begin
            w(2);
            sda_drv = s[k];
            w(3);
            scl = 1'b1;
            w(4);
            if (k == 0 && sda_oe === 1'b1)
                acks++;
            scl = 1'b0;
        end
    endtask
    task automatic xfer(input logic [7:0] dev, input logic [7:0] sub,
                        input logic [7:0] d [$], output int acks);
        acks = 0;
        w(4);
        sda_drv = 1'b0;
        w(4);
        scl = 1'b0;
        put(dev, acks);
        put(sub, acks);
        foreach (d[i])
            put(d[i], acks);
        w(2);
        sda_drv = 1'b0;
        w(3);
        scl = 1'b1;
        w(4);
        sda_drv = 1'b1;
        w(4);
    endtask
endmodule

// file: testbench/tb_top.sv
// Self-checking bench for the FM configuration block.
module tb_top
    import fm_cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] ADR = {DEV_ADDR, 1'b0};
    logic clock, sys_rst, scl, sda_drv, sda_in, sda_out, sda_oe, chk;
    ident_t ident;
    bw_config_t bw_config;
    logic ident_reset, ident_region_select;
    carrier_deemph_t deemph_carrier1, deemph_carrier2;
    dematrix_t dematrix_mode;
    logic [7:0] r9, r10, r11;
    logic [18:0] exp_q [$];
    int miscompares, num_checks, cycles, seed, k;
    assign sda_in = sda_drv & ~(sda_oe & ~sda_out);
    bus_host_model host (.clock(clock), .sda_oe(sda_oe), .scl(scl),
        .sda_drv(sda_drv));
    fm_deemph_dematrix_config i_dut (.clock(clock), .sys_rst(sys_rst),
        .scl_in(scl), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
        .ident_result(ident), .bw_config(bw_config),
        .ident_reset(ident_reset), .ident_region_select(ident_region_select),
        .deemph_carrier1(deemph_carrier1), .deemph_carrier2(deemph_carrier2),
        .dematrix_mode(dematrix_mode));
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    function automatic logic [18:0] model_out();
        logic [1:0] c, a, b;
        logic [2:0] dm;
        c = {r9[4], r9[1]};
        a = c == 2'h0 ? BW_NARROW : c == 2'h1 ? BW_EXTRA_WIDE
            : c == 2'h2 ? BW_MEDIUM : BW_WIDE;
        b = c == 2'h1 ? BW_NARROW : a;
        if (!r11[7])
            dm = r11[2:0];
        else if (r9[3:2] == 2'h2 || ident == ID_MONO)
            dm = DM_MONO1;
        else if (ident == ID_DUAL)
            dm = DM_DUAL;
        else
            dm = r9[5] ? DM_STEREO_KOREA : DM_STEREO_EU;
        return {a, b, c != 2'h1 && r9[3:2] == 2'h0, r9[3:2] == 2'h2,
            r9[7:6] == 2'h3, r9[5], r10[3:0], r10[7:4], dm};
    endfunction
    task automatic cmp(input logic [18:0] got, input logic [18:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic report_and_stop();
        if (miscompares == 0 && num_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    task automatic note();
        exp_q.push_back(model_out());
        repeat (4) @(negedge clock);
        chk = 1'b1;
        @(negedge clock);
        chk = 1'b0;
    endtask
    task automatic wr(input logic [7:0] dev, input logic [7:0] sub,
                      input logic [15:0] d, input int n);
        logic [7:0] q [$];
        int a;
        if (n == 2)
            q.push_back(d[15:8]);
        q.push_back(d[7:0]);
        host.xfer(dev, sub, q, a);
        cmp(19'(a), dev == ADR ? 19'(n + 2) : 19'h0);
        if (dev == ADR)
            foreach (q[i])
                case (8'(sub + 8'(i)))
                    SUB_DEMOD_CONFIG: r9 = q[i];
                    SUB_DEEMPH: r10 = q[i];
                    SUB_DEMATRIX: r11 = q[i];
                    default: ;
                endcase
        note();
    endtask
    always @(posedge clock)
        if (chk)
            cmp({bw_config, ident_reset, ident_region_select,
                deemph_carrier1, deemph_carrier2, dematrix_mode},
                exp_q.pop_front());
    always @(posedge clock) begin
        cycles++;
        if (cycles == 60000) begin
            miscompares++;
            report_and_stop();
        end
    end
    initial begin
        {r9, r10, r11} = 24'h0;
        {miscompares, num_checks, cycles, chk} = '0;
        seed = 77;
        ident = ID_MONO;
        sys_rst = 1'b1;
        repeat (8) @(negedge clock);
        sys_rst = 1'b0;
        note();
        for (int c = 0; c < 4; c++)
            wr(ADR, SUB_DEMOD_CONFIG, {8'h0, 2'h0, 1'b0, c[1],
                ($random(seed) % 2 != 0) ? 2'h2 : 2'h0, c[0], 1'b0}, 1);
        wr(ADR, SUB_DEMOD_CONFIG, 16'h00c0, 1);
        for (int c = 0; c < 5; c++) begin
            k = {$random(seed)} % 5;
            wr(ADR, SUB_DEEMPH, {9'h0, 3'(k), 1'b0, 3'(c)}, 1);
        end
        wr(ADR, SUB_DEEMPH, 16'h00aa, 1);
        wr(ADR, SUB_DEEMPH, 16'h002a, 1);
        for (int m = 0; m < 7; m++)
            wr(ADR, SUB_DEMATRIX, {13'h0, 3'(m)}, 1);
        wr(ADR, SUB_DEEMPH, {8'h40, 8'h85}, 2);
        for (int j = 0; j < 4; j++) begin
            wr(ADR, SUB_DEMOD_CONFIG, {10'h0, j[0], 1'b0, j[1], 3'h0}, 1);
            for (int i = 0; i < 3; i++) begin
                ident = ident_t'(i);
                note();
            end
        end
        wr(ADR | 8'h01, SUB_DEMATRIX, 16'h0000, 1);
        wr(8'h5a, SUB_DEMATRIX, 16'h0000, 1);
        sys_rst = 1'b1;
        @(negedge clock);
        sys_rst = 1'b0;
        {r9, r10, r11} = 24'h0;
        note();
        report_and_stop();
    end
endmodule
